// file: logic/seq_pkg.sv
// Constants and types of the SPI master sequencer
// How it works
// (RULE_01) Guard timer bounds each wait-for-ready poll
// (RULE_02) Exchange starts only after ready; target pulls low
// (RULE_03) Status check: three exchanges, then validate reply
// (RULE_04) Burst: command first, then transmit characters
// (RULE_05) Burst only if reported count covers configured
// (RULE_06) Burst is count plus one; store from second
// (RULE_07) Receive burst only if reported count suffices
// (RULE_08) Status timeout: toggle choice, clear flag, deselect
// (RULE_09) Choice zero selects first target, one second
// (RULE_10) Both targets share one wait line
// (RULE_11) One command sequence per periodic slot tick
// (RULE_12) Eight bits out and in, then done event
package seq_pkg;
  // ----------
  // Timing
  // ----------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int SLOT_PERIOD_NS = 1000000;
  localparam int SLOT_CYCLES    = SLOT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SCK_PERIOD_NS  = 32;
  localparam int SCK_HALF_CYC   = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int GUARD_PRESCALE = 16;
  localparam int CHAR_BITS      = 8;
  localparam int SYNC_STAGES    = 2;

  // ----------
  // Register map
  // ----------
  localparam int          ADDR_W       = 10;
  localparam int          DATA_W       = 32;
  localparam logic [9:0]  REG_CTRL     = 10'h000;
  localparam logic [9:0]  REG_COUNT    = 10'h004;
  localparam logic [9:0]  REG_CMD      = 10'h008;
  localparam logic [9:0]  REG_STATE    = 10'h00C;
  localparam logic [9:0]  REG_INT_STAT = 10'h010;
  localparam logic [9:0]  REG_INT_CLR  = 10'h014;
  localparam logic [9:0]  REG_INT_EN   = 10'h018;
  localparam logic [9:0]  REG_GUARD    = 10'h01C;
  localparam logic [1:0]  WIN_TX       = 2'h1;
  localparam logic [1:0]  WIN_RX       = 2'h2;
  localparam int          MEM_DEPTH    = 64;
  localparam int          CNT_W        = 6;

  // Reset values
  localparam logic [5:0]  COUNT_RST    = 6'h20;
  localparam logic [31:0] CMD_RST      = 32'hA5020401;
  localparam logic [7:0]  GUARD_RST    = 8'hFF;
  localparam logic [7:0]  DUMMY_CHAR   = 8'hFF;

  // Control and state fields
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_RXMODE  = 1;
  localparam int ST_CHOICE    = 0;
  localparam int ST_CONFIRMED = 1;
  localparam int ST_TIMEOUT   = 2;
  localparam int ST_ACTIVE    = 3;
  localparam int ST_AVAIL_LSB = 8;

  // Command register fields
  localparam int CMD_STATUS_LSB = 0;
  localparam int CMD_TXRX_LSB   = 8;
  localparam int CMD_RX_LSB     = 16;
  localparam int CMD_ACK_LSB    = 24;

  // Interrupt status bits
  localparam int IRQ_W        = 4;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_TIMEOUT  = 1;
  localparam int IRQ_STATFAIL = 2;
  localparam int IRQ_SKIP     = 3;

  // Status exchange positions
  localparam logic [6:0] STATUS_LAST = 7'h02;
  localparam int         STAT_AVAIL  = 1;
  localparam int         STAT_ACK    = 2;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WAIT = 3'b001,
    S_XFER = 3'b010,
    S_END  = 3'b011
  } seq_state_t;
endpackage : seq_pkg

// file: logic/guard_wait.sv
// Ready poll of the wait line under an 8-bit guard timer
`timescale 1ns/1ps
`default_nettype none
module guard_wait
  import seq_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_start,
  input  wire logic       i_wait_in,
  input  wire logic [7:0] i_limit,
  output logic            o_ready,
  output logic            o_timeout
);
  logic       running_q;
  logic [7:0] count_q;
  logic [7:0] pre_q;
  logic       guard_timer_expired;
  logic       guard_timer_event;

  // ----------
  // Guard timer
  // ----------
  assign guard_timer_event = running_q && pre_q == 8'(GUARD_PRESCALE - 1) && count_q == i_limit;

  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_start || !running_q) begin
      pre_q   <= 8'h00;
      count_q <= 8'h00;
    end else if (pre_q == 8'(GUARD_PRESCALE - 1)) begin
      pre_q   <= 8'h00;
      count_q <= count_q + 8'h01;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // Cleared at every stop: next wait starts clean
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_start) begin
      guard_timer_expired <= 1'b0;
    end else if (guard_timer_event) begin
      guard_timer_expired <= 1'b1;
    end else if (o_ready || o_timeout) begin
      guard_timer_expired <= 1'b0;
    end
  end

  // ----------
  // Poll: expiry checked ahead of the wait line
  // ----------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      running_q <= 1'b0;
      o_ready   <= 1'b0;
      o_timeout <= 1'b0;
    end else begin
      o_ready   <= 1'b0;
      o_timeout <= 1'b0;
      if (i_start) begin
        running_q <= 1'b1;
      end else if (running_q && guard_timer_expired) begin
        running_q <= 1'b0;                              // [RULE_01]
        o_timeout <= 1'b1;
      end else if (running_q && !i_wait_in) begin
        running_q <= 1'b0;                              // [RULE_01] [RULE_02]
        o_ready   <= 1'b1;
      end
    end
  end
endmodule : guard_wait
`default_nettype wire

// file: logic/spi_byte_shifter.sv
// One 8-bit full-duplex exchange, clock idle low, MSB first
`timescale 1ns/1ps
`default_nettype none
module spi_byte_shifter
  import seq_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_start,
  input  wire logic [7:0] i_tx_char,
  input  wire logic       i_miso,
  output logic            o_sck,
  output logic            o_mosi,
  output logic            o_done,
  output logic [7:0]      o_rx_char
);
  logic       active_q;
  logic [7:0] half_q;
  logic [3:0] edge_q;
  logic [7:0] shift_q;
  logic       tick;

  assign tick = active_q && half_q == 8'(SCK_HALF_CYC - 1);

  always_ff @(posedge i_clk) begin
    if (!i_rstn || !active_q || tick) begin
      half_q <= 8'h00;
    end else begin
      half_q <= half_q + 8'h01;
    end
  end

  // Data set up on falling edges, sampled on rising edges
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      active_q  <= 1'b0;
      edge_q    <= 4'h0;
      shift_q   <= 8'h00;
      o_sck     <= 1'b0;
      o_mosi    <= 1'b0;
      o_done    <= 1'b0;
      o_rx_char <= 8'h00;
    end else begin
      o_done <= 1'b0;
      if (i_start && !active_q) begin
        active_q <= 1'b1;
        edge_q   <= 4'h0;
        shift_q  <= {i_tx_char[6:0], 1'b0};
        o_mosi   <= i_tx_char[CHAR_BITS-1];
      end else if (tick) begin
        o_sck  <= ~o_sck;
        edge_q <= edge_q + 4'h1;
        if (!o_sck) begin
          o_rx_char <= {o_rx_char[6:0], i_miso};       // [RULE_12]
        end else if (edge_q == 4'(2 * CHAR_BITS - 1)) begin
          active_q <= 1'b0;
          o_done   <= 1'b1;                             // [RULE_12]
        end else begin
          o_mosi  <= shift_q[CHAR_BITS-1];
          shift_q <= {shift_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule : spi_byte_shifter
`default_nettype wire

// file: logic/handshake_spi_master_sequencer.sv
// Slot-based SPI master sequencer with shared wait-line handshake
`timescale 1ns/1ps
`default_nettype none
module handshake_spi_master_sequencer
  import seq_pkg::*;
#(
  parameter int SLOT_CYC = SLOT_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [9:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_irq,
  input  wire logic        i_target_wait_input,
  input  wire logic        i_miso,
  output logic             o_sck,
  output logic             o_mosi,
  output logic             o_first_target_select_n,
  output logic             o_second_target_select_n
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [1:0]       wait_sync_q;
  logic [1:0]       miso_sync_q;
  logic [1:0]       ctrl_q;
  logic [CNT_W-1:0] count_q;
  logic [31:0]      cmd_q;
  logic [7:0]       guard_q;
  logic [IRQ_W-1:0] int_stat_q;
  logic [IRQ_W-1:0] int_en_q;
  logic [IRQ_W-1:0] ev_d;
  logic [IRQ_W-1:0] clr_d;
  logic [7:0]       tx_mem [MEM_DEPTH];
  logic [7:0]       rx_mem [MEM_DEPTH];
  logic [7:0]       stat_q [3];
  logic [31:0]      slot_q;
  logic             slot_tick;
  seq_state_t       state_q;
  logic [6:0]       cnt_q;
  logic             burst_q;
  logic             choice_q;
  logic             confirmed_q;
  logic             timeout_q;
  logic             sel_on_q;
  logic             guard_start_q;
  logic             wait_ready;
  logic             wait_timeout;
  logic             xfer_start;
  logic             transfer_done_event;
  logic [7:0]       rx_char;
  logic [7:0]       tx_char_d;
  logic             stat_ok;
  logic             avail_ok;
  logic             burst_last;
  logic [31:0]      rdata_d;
  logic             sck_w;
  logic             mosi_w;

  // Byte lane of a command register field
  function automatic logic [7:0] field8(input logic [31:0] w, input int lsb);
    field8 = w[lsb +: 8];
  endfunction : field8

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wait_sync_q <= 2'h3;
      miso_sync_q <= 2'h0;
    end else begin
      wait_sync_q <= {wait_sync_q[0], i_target_wait_input};
      miso_sync_q <= {miso_sync_q[0], i_miso};
    end
  end

  // ---------------------------------------------------------------
  // Slot timer
  // ---------------------------------------------------------------
  assign slot_tick = slot_q == 32'(SLOT_CYC - 1);

  always_ff @(posedge i_clk) begin
    if (!i_rstn || slot_tick || !ctrl_q[CTRL_ENABLE]) begin
      slot_q <= 32'h0;
    end else begin
      slot_q <= slot_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  guard_wait u_guard (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_start   (guard_start_q),
    .i_wait_in (wait_sync_q[1]),
    .i_limit   (guard_q),
    .o_ready   (wait_ready),
    .o_timeout (wait_timeout)
  );

  spi_byte_shifter u_shift (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_start   (xfer_start),
    .i_tx_char (tx_char_d),
    .i_miso    (miso_sync_q[1]),
    .o_sck     (sck_w),
    .o_mosi    (mosi_w),
    .o_done    (transfer_done_event),
    .o_rx_char (rx_char)
  );

  // ---------------------------------------------------------------
  // Sequence decisions
  // ---------------------------------------------------------------
  assign xfer_start = state_q == S_WAIT && wait_ready;             // [RULE_02]
  assign stat_ok    = rx_char == field8(cmd_q, CMD_ACK_LSB);        // [RULE_03]
  assign avail_ok   = stat_q[STAT_AVAIL] >= 8'(count_q);            // [RULE_05] [RULE_07]
  assign burst_last = cnt_q == 7'(count_q);                         // [RULE_06]

  always_comb begin
    tx_char_d = DUMMY_CHAR;
    if (!burst_q) begin
      if (cnt_q == 7'h00) begin
        tx_char_d = field8(cmd_q, CMD_STATUS_LSB);                  // [RULE_03]
      end
    end else if (cnt_q == 7'h00) begin
      tx_char_d = ctrl_q[CTRL_RXMODE] ? field8(cmd_q, CMD_RX_LSB)
                                      : field8(cmd_q, CMD_TXRX_LSB); // [RULE_04]
    end else if (!ctrl_q[CTRL_RXMODE]) begin
      tx_char_d = tx_mem[6'(cnt_q - 7'h01)];                        // [RULE_04]
    end
  end

  // ---------------------------------------------------------------
  // Slot state machine
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q       <= S_IDLE;
      cnt_q         <= 7'h00;
      burst_q       <= 1'b0;
      guard_start_q <= 1'b0;
    end else begin
      guard_start_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (slot_tick) begin
            state_q       <= S_WAIT;                       // [RULE_11]
            cnt_q         <= 7'h00;
            burst_q       <= 1'b0;
            guard_start_q <= 1'b1;
          end
        end
        S_WAIT: begin
          if (wait_timeout) begin
            state_q <= burst_q ? S_END : S_IDLE;
          end else if (wait_ready) begin
            state_q <= S_XFER;
          end
        end
        S_XFER: begin
          if (transfer_done_event) begin
            if (!burst_q && cnt_q == STATUS_LAST) begin
              if (stat_ok && avail_ok) begin
                state_q       <= S_WAIT;                   // [RULE_05] [RULE_07]
                burst_q       <= 1'b1;
                cnt_q         <= 7'h00;
                guard_start_q <= 1'b1;
              end else begin
                state_q <= S_END;
              end
            end else if (burst_q && burst_last) begin
              state_q <= S_END;                            // [RULE_06]
            end else begin
              state_q       <= S_WAIT;
              cnt_q         <= cnt_q + 7'h01;
              guard_start_q <= 1'b1;
            end
          end
        end
        S_END: begin
          state_q <= S_IDLE;                               // [RULE_11]
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Target choice, select and confirmation flags
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      choice_q    <= 1'b0;
      confirmed_q <= 1'b0;
      sel_on_q    <= 1'b0;
      timeout_q   <= 1'b0;
    end else begin
      if (state_q == S_IDLE && slot_tick) begin
        sel_on_q  <= 1'b1;
        timeout_q <= 1'b0;
      end
      if (state_q == S_WAIT && wait_timeout) begin
        timeout_q <= 1'b1;
        if (!burst_q) begin
          choice_q    <= ~choice_q;                        // [RULE_08]
          confirmed_q <= 1'b0;
          sel_on_q    <= 1'b0;
        end
      end
      if (state_q == S_XFER && transfer_done_event && !burst_q && cnt_q == STATUS_LAST) begin
        confirmed_q <= stat_ok;                            // [RULE_03]
      end
      if (state_q == S_END) begin
        choice_q    <= ~choice_q;
        confirmed_q <= 1'b0;
        sel_on_q    <= 1'b0;
      end
    end
  end

  // Pin outputs come from flops; selects are active low
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_first_target_select_n  <= 1'b1;
      o_second_target_select_n <= 1'b1;
      o_sck                    <= 1'b0;
      o_mosi                   <= 1'b0;
    end else begin
      o_first_target_select_n  <= ~(sel_on_q && !choice_q);  // [RULE_09]
      o_second_target_select_n <= ~(sel_on_q && choice_q);   // [RULE_09] [RULE_10]
      o_sck                    <= sck_w;
      o_mosi                   <= mosi_w;
    end
  end

  // ---------------------------------------------------------------
  // Received characters
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (state_q == S_XFER && transfer_done_event) begin
      if (!burst_q) begin
        stat_q[2'(cnt_q)] <= rx_char;                      // [RULE_03]
      end else if (cnt_q != 7'h00) begin
        rx_mem[6'(cnt_q - 7'h01)] <= rx_char;              // [RULE_06]
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status: set wins over clear
  // ---------------------------------------------------------------
  always_comb begin
    ev_d = '0;
    ev_d[IRQ_TIMEOUT]  = state_q == S_WAIT && wait_timeout;
    ev_d[IRQ_DONE]     = state_q == S_XFER && transfer_done_event && burst_q && burst_last;
    ev_d[IRQ_STATFAIL] = state_q == S_XFER && transfer_done_event && !burst_q
                         && cnt_q == STATUS_LAST && !stat_ok;
    ev_d[IRQ_SKIP]     = state_q == S_XFER && transfer_done_event && !burst_q
                         && cnt_q == STATUS_LAST && stat_ok && !avail_ok;
    clr_d = (i_wr && i_addr == REG_INT_CLR) ? i_wdata[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      int_stat_q <= '0;
      o_irq      <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~clr_d) | ev_d;
      o_irq      <= |(((int_stat_q & ~clr_d) | ev_d) & int_en_q);
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_q   <= 2'h0;
      count_q  <= COUNT_RST;
      cmd_q    <= CMD_RST;
      guard_q  <= GUARD_RST;
      int_en_q <= '0;
    end else if (i_wr) begin
      if (i_addr == REG_CTRL) begin
        ctrl_q <= i_wdata[1:0];
      end else if (i_addr == REG_COUNT) begin
        count_q <= i_wdata[CNT_W-1:0];
      end else if (i_addr == REG_CMD) begin
        cmd_q <= i_wdata;
      end else if (i_addr == REG_GUARD) begin
        guard_q <= i_wdata[7:0];
      end else if (i_addr == REG_INT_EN) begin
        int_en_q <= i_wdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_wr && i_addr[9:8] == WIN_TX) begin
      tx_mem[i_addr[7:2]] <= i_wdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0;
    if (i_addr == REG_CTRL) begin
      rdata_d[1:0] = ctrl_q;
    end else if (i_addr == REG_COUNT) begin
      rdata_d[CNT_W-1:0] = count_q;
    end else if (i_addr == REG_CMD) begin
      rdata_d = cmd_q;
    end else if (i_addr == REG_STATE) begin
      rdata_d[ST_CHOICE]                 = choice_q;
      rdata_d[ST_CONFIRMED]              = confirmed_q;
      rdata_d[ST_TIMEOUT]                = timeout_q;
      rdata_d[ST_ACTIVE]                 = state_q != S_IDLE;
      rdata_d[ST_AVAIL_LSB +: 8]         = stat_q[STAT_AVAIL];
    end else if (i_addr == REG_INT_STAT) begin
      rdata_d[IRQ_W-1:0] = int_stat_q;
    end else if (i_addr == REG_INT_EN) begin
      rdata_d[IRQ_W-1:0] = int_en_q;
    end else if (i_addr == REG_GUARD) begin
      rdata_d[7:0] = guard_q;
    end else if (i_addr[9:8] == WIN_TX) begin
      rdata_d[7:0] = tx_mem[i_addr[7:2]];
    end else if (i_addr[9:8] == WIN_RX) begin
      rdata_d[7:0] = rx_mem[i_addr[7:2]];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 32'h0;
    end
  end
endmodule : handshake_spi_master_sequencer
`default_nettype wire

// file: verification/seq_props.sv
// Port-level assertions of the sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_props
  import seq_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic [9:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_irq,
  input wire logic        i_target_wait_input,
  input wire logic        o_sck,
  input wire logic        o_mosi,
  input wire logic        o_first_target_select_n,
  input wire logic        o_second_target_select_n
);
  logic       sel;
  logic       sck_q;
  logic       rdy_q;
  logic [2:0] rise_q;
  assign sel = !o_first_target_select_n || !o_second_target_select_n;
  // A first rise needs a low wait line seen under select
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sck_q  <= 1'b0;
      rise_q <= 3'h0;
      rdy_q  <= 1'b0;
    end else begin
      sck_q  <= o_sck;
      rise_q <= !sel ? 3'h0 : rise_q + 3'(o_sck && !sck_q);
      rdy_q  <= (!sel || (o_sck && !sck_q && rise_q == 3'h0)) ? 1'b0
                : rdy_q || !i_target_wait_input;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_high;
    o_sck [*4] ##1 !o_sck;
  endsequence
  AST_ONE_SELECT: assert property (o_first_target_select_n || o_second_target_select_n)
    else $error("two selects");
  AST_SCK_HIGH: assert property ($rose(o_sck) |-> s_high)
    else $error("sck high phase");
  AST_SCK_LOW: assert property ($fell(o_sck) |-> !o_sck [*4])
    else $error("sck low phase");
  AST_READY_FIRST: assert property ($rose(o_sck) && rise_q == 3'h0 |-> rdy_q)
    else $error("start without ready");
  AST_MOSI_HOLD: assert property (o_sck && $past(o_sck) |-> $stable(o_mosi))
    else $error("mosi moved");
  AST_SELECT_HOLD: assert property ($rose(o_sck) |-> sel throughout s_high)
    else $error("select dropped");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("stray read data");
  AST_IRQ_CLEAR: assert property (i_wr && i_addr == REG_INT_CLR && i_wdata[3:0] == 4'hF && !sel
    |-> ##2 !o_irq)
    else $error("irq after clear");
  AST_RESET_OUT: assert property (disable iff (1'b0) !i_rstn |=> !o_sck && !o_irq
    && o_first_target_select_n && o_second_target_select_n && o_rdata == 32'h0)
    else $error("reset outputs");
endmodule : seq_props

bind handshake_spi_master_sequencer seq_props u_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_target_wait_input(i_target_wait_input),
  .o_sck(o_sck), .o_mosi(o_mosi), .o_first_target_select_n(o_first_target_select_n),
  .o_second_target_select_n(o_second_target_select_n));
`default_nettype wire

// file: verification/spi_target_pair.sv
// Model of two SPI targets on one wait line
`timescale 1ns/1ps
`default_nettype none
module spi_target_pair
  import seq_pkg::*;
#(
  parameter logic [7:0] AVAIL = 8'h08
) (
  input  wire logic       i_clk,
  input  wire logic       i_sel1_n,
  input  wire logic       i_sel2_n,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic [1:0] i_mute,
  input  wire logic [7:0] i_dly,
  output logic            o_wait,
  output logic            o_miso
);
  logic [7:0] sh = 8'h00;
  logic [7:0] inb = 8'h00;
  logic [7:0] heard [0:15];
  logic       busy = 1'b0;
  logic       flip = 1'b0;
  logic       sel;
  logic       mute;
  int         idx = 0;
  int         bits = 0;
  int         gap = 0;
  assign sel  = !i_sel1_n || !i_sel2_n;
  assign mute = (!i_sel1_n && i_mute[0]) || (!i_sel2_n && i_mute[1]);
  // Selected idle target pulls low after a delay
  assign o_wait = !(sel && !mute && !busy && gap >= int'(i_dly));
  // Released line toggles: no stale bit
  assign o_miso = sel ? sh[7] : flip;
  function automatic logic [7:0] reply(input int k);
    return (k == 1) ? AVAIL : (k == 2) ? CMD_RST[CMD_ACK_LSB +: 8] : 8'(k + 8'h40);
  endfunction : reply
  always @(negedge sel) begin
    idx = 0;
    bits = 0;
    busy = 1'b0;
    sh = reply(0);
  end
  always @(posedge i_sck) if (sel) begin
    inb = {inb[6:0], i_mosi};
    busy = 1'b1;
    bits++;
    if (bits == 8 && idx < 16) heard[idx] = inb;
  end
  always @(negedge i_sck) if (sel) begin
    if (bits == 8) begin
      idx++;
      bits = 0;
      busy = 1'b0;
      sh = reply(idx);
    end else sh = sh << 1;
  end
  always @(posedge i_clk) begin
    flip <= sel ? sh[7] : !flip;
    gap  <= (busy || !sel) ? 0 : (gap < 255 ? gap + 1 : gap);
  end
endmodule : spi_target_pair
`default_nettype wire

// file: verification/handshake_spi_master_sequencer_test.sv
// Self-checking bench of the sequencer
`timescale 1ns/1ps
`default_nettype none
module handshake_spi_master_sequencer_test;
  import seq_pkg::*;
  localparam logic [7:0]  AVAIL = 8'h08;
  localparam logic [9:0]  RA [7] = '{REG_CTRL, REG_COUNT, REG_CMD, REG_GUARD,
                                     REG_INT_STAT, REG_INT_CLR, 10'h300};
  localparam logic [31:0] RV [7] = '{32'h0, 32'h20, CMD_RST, 32'hFF, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] IRQ_EXP [5] = '{32'h1, 32'h1, 32'h8, 32'h2, 32'h4};
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [9:0]  i_addr = 10'h000;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] o_rdata;
  logic [31:0] got;
  logic        o_irq, target_wait, miso, o_sck, o_mosi, sel1_n, sel2_n, choice;
  logic [1:0]  mute = 2'h0;
  logic [7:0]  dly = 8'h00;
  logic [7:0]  tx [0:15];
  int          err_count = 0;
  int          samples_checked = 0;
  int          seed = 84;
  int          cnt;
  int          n;
  always #2 i_clk = ~i_clk;

  handshake_spi_master_sequencer #(.SLOT_CYC(2000)) uut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_target_wait_input(target_wait),
    .i_miso(miso), .o_sck(o_sck), .o_mosi(o_mosi), .o_first_target_select_n(sel1_n),
    .o_second_target_select_n(sel2_n));
  spi_target_pair #(.AVAIL(AVAIL)) peer (
    .i_clk(i_clk), .i_sel1_n(sel1_n), .i_sel2_n(sel2_n), .i_sck(o_sck), .i_mosi(o_mosi),
    .i_mute(mute), .i_dly(dly), .o_wait(target_wait), .o_miso(miso));

  // ----------
  // Bus, checks, closing
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 got = o_rdata;
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  function automatic logic [7:0] mosi_exp(input int k, input int m);
    if (k == 0) return CMD_RST[CMD_STATUS_LSB +: 8];
    if (k < 3) return DUMMY_CHAR;
    if (k == 3) return m ? CMD_RST[CMD_RX_LSB +: 8] : CMD_RST[CMD_TXRX_LSB +: 8];
    return m ? DUMMY_CHAR : tx[k - 4];
  endfunction : mosi_exp

  // ----------
  // Modes: 0 burst, 1 receive, 2 count short, 3 silent, 4 bad ack
  // ----------
  initial begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(RA[i]);
      chk(got, RV[i]);
    end
    $display("resets done");
    wr(REG_GUARD, 32'h3);
    wr(REG_INT_EN, 32'hF);
    for (int m = 0; m < 5; m++) begin
      cnt = (m == 2) ? AVAIL + 1 : $random(seed) & 7;
      for (int j = 0; j < cnt; j++) begin
        tx[j] = 8'($random(seed));
        wr(10'h100 + 10'(4 * j), {24'h0, tx[j]});
      end
      dly <= 8'($random(seed) & 15);
      wr(REG_CMD, (m == 4) ? {8'h5A, CMD_RST[23:0]} : CMD_RST);
      wr(REG_COUNT, cnt);
      rd(REG_STATE);
      choice = got[ST_CHOICE];
      mute <= (m == 3) ? {choice, !choice} : 2'h0;
      wr(REG_CTRL, {30'h0, m == 1, 1'b1});
      for (n = 0; n < 5000 && o_irq !== 1'b1; n++) @(posedge i_clk);
      if (n == 5000) begin
        err_count++;
        wrap_up();
      end
      wr(REG_CTRL, 32'h0);
      rd(REG_INT_STAT);
      chk(got, IRQ_EXP[m]);
      rd(REG_STATE);
      chk(got[ST_CHOICE], !choice);
      chk(got[ST_CONFIRMED], 1'b0);
      chk(got[15:2], {AVAIL, 4'h0, 1'b0, m == 3});
      if (m < 2) begin
        for (int k = 0; k < cnt + 4; k++) chk(peer.heard[k], mosi_exp(k, m));
        for (int j = 0; j < cnt; j++) begin
          rd(10'h200 + 10'(4 * j));
          chk(got, 32'(8'h44 + j));
        end
      end
      // Mask, then clear: line must drop
      wr(REG_INT_EN, 32'h0);
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'b0);
      wr(REG_INT_CLR, 32'hF);
      wr(REG_INT_EN, 32'hF);
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'b0);
      $display("mode %0d done", m);
    end
    wrap_up();
  end
endmodule : handshake_spi_master_sequencer_test
`default_nettype wire
